/* File: common/ncps_defs.vh */
// ncps_defs.vh: constants for the nand cache program / erase / status host controller
// assumes: included by bare name from the design files; definitions only
`ifndef NCPS_DEFS_VH
`define NCPS_DEFS_VH

// nand command opcodes
`define NCPS_CMD_PROG_SETUP   8'h80
`define NCPS_CMD_CACHE_CONF   8'h15
`define NCPS_CMD_PROG_CONF    8'h10
`define NCPS_CMD_ERASE_SETUP  8'h60
`define NCPS_CMD_ERASE_CONF   8'hD0
`define NCPS_CMD_STATUS       8'h70
`define NCPS_CMD_READ         8'h00
`define NCPS_CMD_ID           8'h90
`define NCPS_ID_ADDR          8'h00

// address cycle counts and id byte count
`define NCPS_PROG_ADDR_CYC    3'h5
`define NCPS_ERASE_ADDR_CYC   3'h3
`define NCPS_ID_BYTES         3'h5

// page size in bus units (x8 bytes / x16 words)
`define NCPS_PAGE_X8          13'h1100
`define NCPS_PAGE_X16         13'h0880

// operation_status bit positions
`define NCPS_SR_FAIL_N        0
`define NCPS_SR_FAIL_N1       1
`define NCPS_SR_ARRAY_RDY     5
`define NCPS_SR_CACHE_RDY     6
`define NCPS_SR_WP_N          7

// host register offsets (byte addresses)
`define NCPS_REG_CTRL         8'h00
`define NCPS_REG_ADDR_LO      8'h04
`define NCPS_REG_ADDR_HI      8'h08
`define NCPS_REG_DATA         8'h0C
`define NCPS_REG_STATUS       8'h10
`define NCPS_REG_ID_LO        8'h14
`define NCPS_REG_ID_HI        8'h18

// ctrl register fields
`define NCPS_CTRL_OP_LSB      0
`define NCPS_CTRL_LAST_BIT    4
`define NCPS_CTRL_X16_BIT     5
`define NCPS_CTRL_GO_BIT      8

// host operation codes
`define NCPS_OP_CACHE_PROG    3'h1
`define NCPS_OP_ERASE         3'h2
`define NCPS_OP_STATUS        3'h3
`define NCPS_OP_READ_ID       3'h4

// pin timing: strobe low and high phases, and hclk period (ns)
`define NCPS_T_STROBE_NS      25
`define NCPS_CLK_NS           5

`endif

/* File: hdl/ncps_pin_sync.v */
// ncps_pin_sync.v: three-flop synchroniser with agreement filter
// assumes: din is asynchronous to hclk; dout changes once flops two and three agree
`timescale 1ns/10ps
`default_nettype none

module ncps_pin_sync #(
	parameter W = 1
) (
	// clock and reset
	input  wire         hclk,
	input  wire         hresetn,
	// pins
	input  wire [W-1:0] din,
	output reg  [W-1:0] dout
);

	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;

	// s1 feeds only s2, so metastability never reaches logic
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_q <= {W{1'b0}};
			s2_q <= {W{1'b0}};
			s3_q <= {W{1'b0}};
			dout <= {W{1'b0}};
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				dout <= s3_q;
		end
	end

endmodule // ncps_pin_sync

`default_nettype wire

/* File: hdl/ncps_host.v */
// ncps_host.v: ahb-lite controlled host that drives a nand device through its pins
// assumes: one device on the bus; software writes one data word per page unit; single clock
`timescale 1ns/10ps
`default_nettype none
`include "ncps_defs.vh"

module ncps_host #(
	parameter STROBE_CYC = (`NCPS_T_STROBE_NS + `NCPS_CLK_NS - 1) / `NCPS_CLK_NS
) (
	// clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// ahb-lite slave
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	// nand pins
	output reg         nand_ce_n,
	output reg         nand_cle,
	output reg         nand_ale,
	output reg         nand_we_n,
	output reg         nand_re_n,
	output reg  [15:0] nand_io_out,
	output reg         nand_io_oe,
	input  wire [15:0] nand_io_in,
	input  wire        nand_rb_n
);

	// states of the nand pin sequencer, from start to done
	localparam S_IDLE   = 4'h0;
	localparam S_CMD    = 4'h1;
	localparam S_ADDR   = 4'h2;
	localparam S_DATA   = 4'h3;
	localparam S_WAIT   = 4'h4;
	localparam S_CONF   = 4'h5;
	localparam S_POLLC  = 4'h6;
	localparam S_POLLR  = 4'h7;
	localparam S_IDREAD = 4'h8;
	localparam S_DONE   = 4'h9;

	// register state
	reg [2:0]  op_q;
	reg        last_q;
	reg        x16_q;
	reg        busy_q;
	reg [31:0] addr_lo_q;
	reg [7:0]  addr_hi_q;
	reg [15:0] wdata_q;
	reg        wvalid_q;
	reg [7:0]  status_q;
	reg [39:0] id_q;
	reg        err_q;
	reg        go_q;

	// pin machine state
	reg [3:0]  st_q;
	reg [3:0]  ret_q;
	reg [2:0]  cnt_q;
	reg [12:0] dcnt_q;
	reg [7:0]  tmr_q;
	reg [1:0]  ph_q;
	reg        conf_sent_q;

	// ahb address phase capture
	reg        dp_wr_q;
	reg        dp_rd_q;
	reg [7:0]  dp_addr_q;

	wire [15:0] io_s;
	wire        rb_s;

	ncps_pin_sync #(.W(17)) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.din     ({nand_rb_n, nand_io_in}),
		.dout    ({rb_s, io_s})
	);

	// data register stalls the bus until the pin machine has taken the previous word
	wire stall = dp_wr_q && (dp_addr_q == `NCPS_REG_DATA) && wvalid_q;
	assign hreadyout = ~stall;
	assign hresp     = 1'b0;

	wire [12:0] page_units = x16_q ? `NCPS_PAGE_X16 : `NCPS_PAGE_X8;
	wire        tick = (tmr_q == 8'h00);
	wire        take = hsel && hready && htrans[1];

	// ahb address phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_q   <= 1'b0;
			dp_rd_q   <= 1'b0;
			dp_addr_q <= 8'h00;
		end else if (hreadyout) begin
			dp_wr_q   <= take && hwrite;
			dp_rd_q   <= take && !hwrite;
			dp_addr_q <= haddr;
		end
	end

	// read data register
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (take && !hwrite) begin
			case (haddr)
				// a pending go reads as busy; a poll whose address phase overlaps the start write's data phase still reads idle
				`NCPS_REG_CTRL:    hrdata <= {22'h0, err_q, busy_q | go_q, 2'h0, x16_q, last_q, 1'b0, op_q};
				`NCPS_REG_ADDR_LO: hrdata <= addr_lo_q;
				`NCPS_REG_ADDR_HI: hrdata <= {24'h000000, addr_hi_q};
				`NCPS_REG_STATUS:  hrdata <= {24'h000000, status_q};
				`NCPS_REG_ID_LO:   hrdata <= id_q[31:0];
				`NCPS_REG_ID_HI:   hrdata <= {24'h000000, id_q[39:32]};
				default:           hrdata <= 32'h00000000;
			endcase
		end
	end

	// software writes; go is a one-cycle start that is ignored while busy
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			op_q      <= 3'h0;
			last_q    <= 1'b0;
			x16_q     <= 1'b0;
			addr_lo_q <= 32'h00000000;
			addr_hi_q <= 8'h00;
			go_q      <= 1'b0;
		end else begin
			go_q <= 1'b0;
			// after the confirm the sequencer only sends status reads
			if (st_q == S_WAIT && rb_s)
				op_q <= `NCPS_OP_STATUS;
			if (dp_wr_q && !stall) begin
				case (dp_addr_q)
					`NCPS_REG_CTRL: begin
						op_q   <= hwdata[2:0];
						last_q <= hwdata[`NCPS_CTRL_LAST_BIT];
						x16_q  <= hwdata[`NCPS_CTRL_X16_BIT];
						go_q   <= hwdata[`NCPS_CTRL_GO_BIT] && !busy_q;
					end
					`NCPS_REG_ADDR_LO: addr_lo_q <= hwdata;
					`NCPS_REG_ADDR_HI: addr_hi_q <= hwdata[7:0];
					default: ;
				endcase
			end
		end
	end

	// timer parked at full count while waiting, so no strobe phase comes out short
	wire tmr_hold = (st_q == S_IDLE) || (st_q == S_CONF) || (st_q == S_WAIT) ||
		(st_q == S_DATA && ph_q == 2'h0 && (!wvalid_q || dcnt_q == page_units));

	// strobe phase timer: ph 0 setup low, ph 1 high
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			tmr_q <= 8'h00;
		else if (tmr_hold || tick)
			tmr_q <= STROBE_CYC[7:0] - 8'h01;
		else
			tmr_q <= tmr_q - 8'h01;
	end

	// address byte selector: program takes five cycles col lo, col hi, row lo, mid, hi; erase takes three cycles row lo, mid, hi
	reg [7:0] addr_byte;
	always @* begin
		case (cnt_q)
			3'h0:    addr_byte = (op_q == `NCPS_OP_ERASE) ? addr_lo_q[23:16] : addr_lo_q[7:0];
			3'h1:    addr_byte = (op_q == `NCPS_OP_ERASE) ? addr_lo_q[31:24] : addr_lo_q[15:8];
			3'h2:    addr_byte = (op_q == `NCPS_OP_ERASE) ? addr_hi_q : addr_lo_q[23:16];
			3'h3:    addr_byte = addr_lo_q[31:24];
			default: addr_byte = addr_hi_q;
		endcase
	end

	wire [2:0] addr_cycles = (op_q == `NCPS_OP_ERASE) ? `NCPS_ERASE_ADDR_CYC :
		(op_q == `NCPS_OP_READ_ID) ? 3'h1 : `NCPS_PROG_ADDR_CYC;

	reg [7:0] cmd_byte;
	always @* begin
		case (op_q)
			`NCPS_OP_CACHE_PROG: cmd_byte = conf_sent_q ? (last_q ? `NCPS_CMD_PROG_CONF
				: `NCPS_CMD_CACHE_CONF) : `NCPS_CMD_PROG_SETUP;
			`NCPS_OP_ERASE:      cmd_byte = conf_sent_q ? `NCPS_CMD_ERASE_CONF : `NCPS_CMD_ERASE_SETUP;
			`NCPS_OP_READ_ID:    cmd_byte = `NCPS_CMD_ID;
			default:             cmd_byte = `NCPS_CMD_STATUS;
		endcase
	end

	// data word handoff from bus to pin machine
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdata_q  <= 16'h0000;
			wvalid_q <= 1'b0;
		end else begin
			if (dp_wr_q && dp_addr_q == `NCPS_REG_DATA && !wvalid_q) begin
				wdata_q  <= hwdata[15:0];
				wvalid_q <= 1'b1;
			end else if (st_q == S_DATA && ph_q == 2'h1 && tick) begin
				wvalid_q <= 1'b0;
			end
		end
	end

	// pin sequencer; while busy it only sends 70h and reads status
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q        <= S_IDLE;
			ret_q       <= S_IDLE;
			cnt_q       <= 3'h0;
			dcnt_q      <= 13'h0000;
			ph_q        <= 2'h0;
			conf_sent_q <= 1'b0;
			busy_q      <= 1'b0;
			err_q       <= 1'b0;
			status_q    <= 8'h00;
			id_q        <= 40'h0000000000;
			nand_ce_n   <= 1'b1;
			nand_cle    <= 1'b0;
			nand_ale    <= 1'b0;
			nand_we_n   <= 1'b1;
			nand_re_n   <= 1'b1;
			nand_io_out <= 16'h0000;
			nand_io_oe  <= 1'b0;
		end else begin
			case (st_q)
				S_IDLE: begin
					nand_ce_n <= 1'b1;
					if (go_q) begin
						busy_q      <= 1'b1;
						conf_sent_q <= 1'b0;
						cnt_q       <= 3'h0;
						dcnt_q      <= 13'h0000;
						ph_q        <= 2'h0;
						nand_ce_n   <= 1'b0;
						st_q        <= S_CMD;
						ret_q       <= (op_q == `NCPS_OP_STATUS) ? S_POLLR : S_ADDR;
					end
				end
				// command latch: cle high, we low then rising edge
				S_CMD: begin
					if (ph_q == 2'h0) begin
						nand_cle    <= 1'b1;
						nand_we_n   <= 1'b0;
						nand_io_oe  <= 1'b1;
						nand_io_out <= {8'h00, cmd_byte};
						if (tick)
							ph_q <= 2'h1;
					end else begin
						nand_we_n <= 1'b1;
						if (tick) begin
							nand_cle <= 1'b0;
							ph_q     <= 2'h0;
							st_q     <= ret_q;
							cnt_q    <= 3'h0;
						end
					end
				end
				S_ADDR: begin
					if (ph_q == 2'h0) begin
						nand_ale    <= 1'b1;
						nand_we_n   <= 1'b0;
						nand_io_oe  <= 1'b1;
						nand_io_out <= (op_q == `NCPS_OP_READ_ID) ? {8'h00, `NCPS_ID_ADDR}
							: {8'h00, addr_byte};
						if (tick)
							ph_q <= 2'h1;
					end else begin
						nand_we_n <= 1'b1;
						if (tick) begin
							ph_q  <= 2'h0;
							cnt_q <= cnt_q + 3'h1;
							if (cnt_q == addr_cycles - 3'h1) begin
								nand_ale <= 1'b0;
								cnt_q    <= 3'h0;
								conf_sent_q <= 1'b1;
								case (op_q)
									`NCPS_OP_CACHE_PROG: st_q <= S_DATA;
									`NCPS_OP_ERASE: begin
										st_q  <= S_CMD;
										ret_q <= S_CONF;
									end
									default: st_q <= S_IDREAD;
								endcase
							end
						end
					end
				end
				// page data from software, capped at one page
				S_DATA: begin
					if (dcnt_q == page_units) begin
						st_q  <= S_CMD;
						ret_q <= S_CONF;
					end else if (ph_q == 2'h0) begin
						if (wvalid_q) begin
							nand_we_n   <= 1'b0;
							nand_io_oe  <= 1'b1;
							nand_io_out <= wdata_q;
							if (tick)
								ph_q <= 2'h1;
						end
					end else begin
						nand_we_n <= 1'b1;
						if (tick) begin
							ph_q   <= 2'h0;
							dcnt_q <= dcnt_q + 13'h0001;
						end
					end
				end
				// confirm sent: wait for busy pin, then poll status
				S_CONF: begin
					nand_io_oe <= 1'b0;
					if (!rb_s)
						st_q <= S_WAIT;
				end
				S_WAIT: begin
					if (rb_s) begin
						ret_q <= (op_q == `NCPS_OP_CACHE_PROG && !last_q) ? S_POLLC : S_POLLR;
						st_q  <= S_CMD;
					end
				end
				// status read: re low, sample, re high
				S_POLLC, S_POLLR: begin
					nand_io_oe <= 1'b0;
					if (ph_q == 2'h0) begin
						nand_re_n <= 1'b0;
						if (tick)
							ph_q <= 2'h1;
					end else begin
						nand_re_n <= 1'b1;
						status_q  <= {io_s[7:5], 3'h0, io_s[1:0]};
						if (tick) begin
							ph_q <= 2'h0;
							if ((st_q == S_POLLC && io_s[`NCPS_SR_CACHE_RDY]) ||
								(st_q == S_POLLR && io_s[`NCPS_SR_ARRAY_RDY])) begin
								err_q <= (st_q == S_POLLC) ? io_s[`NCPS_SR_FAIL_N1]
									: io_s[`NCPS_SR_FAIL_N];
								st_q  <= S_DONE;
							end
						end
					end
				end
				S_IDREAD: begin
					nand_io_oe <= 1'b0;
					if (ph_q == 2'h0) begin
						nand_re_n <= 1'b0;
						if (tick)
							ph_q <= 2'h1;
					end else begin
						nand_re_n <= 1'b1;
						if (tick) begin
							ph_q <= 2'h0;
							id_q <= {io_s[7:0], id_q[39:8]};
							cnt_q <= cnt_q + 3'h1;
							if (cnt_q == `NCPS_ID_BYTES - 3'h1)
								st_q <= S_DONE;
						end
					end
				end
				// status mode stays in device until next command
				S_DONE: begin
					nand_ce_n <= 1'b1;
					busy_q    <= 1'b0;
					st_q      <= S_IDLE;
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

endmodule // ncps_host

`default_nettype wire

/* File: verif/ncps_host_monitor.sv */
// ncps_host_monitor.sv: nand pin checks for the host controller
// assumes: bound into ncps_host; strobe phases of five hclk cycles
`timescale 1ns/10ps
`default_nettype none
module ncps_host_monitor (
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// nand pins
	input wire logic        nand_ce_n,
	input wire logic        nand_cle,
	input wire logic        nand_ale,
	input wire logic        nand_we_n,
	input wire logic        nand_re_n,
	input wire logic [15:0] nand_io_out,
	input wire logic        nand_io_oe,
	input wire logic        nand_rb_n
);
	logic       we_q;
	logic       latch;
	logic [7:0] cmd_q;
	logic [2:0] acnt_q;
	assign latch = nand_we_n && !we_q;
	// last command and address count, taken at each write strobe rise
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			we_q <= 1'b1;
			cmd_q <= 8'hFF;
			acnt_q <= 3'h0;
		end else begin
			we_q <= nand_we_n;
			if (latch && nand_cle) begin
				cmd_q <= nand_io_out[7:0];
				acnt_q <= 3'h0;
			end else if (latch && nand_ale) begin
				acnt_q <= acnt_q + 3'h1;
			end
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_cmd(c);
		latch && nand_cle && nand_io_out[7:0] == c;
	endsequence
	sequence s_low5(s);
		(!s) [*5] ##1 s;
	endsequence
	AST_ERASE_SEQ: assert property (s_cmd(8'hD0) |-> cmd_q == 8'h60 && acnt_q == 3'h3)
		else $error("erase confirm out of order");
	AST_PROG_ADDR: assert property ((s_cmd(8'h15) or s_cmd(8'h10)) |-> cmd_q == 8'h80 && acnt_q == 3'h5)
		else $error("program confirm out of order");
	AST_ID_ADDR: assert property (latch && nand_ale && cmd_q == 8'h90 |-> nand_io_out[7:0] == 8'h00)
		else $error("id address not zero");
	AST_BUSY_CMD: assert property (latch && nand_cle && !nand_rb_n |-> nand_io_out[7:0] == 8'h70)
		else $error("command other than status while busy");
	AST_WE_PULSE: assert property ($fell(nand_we_n) |-> s_low5(nand_we_n))
		else $error("write strobe length");
	AST_RE_PULSE: assert property ($fell(nand_re_n) |-> s_low5(nand_re_n))
		else $error("read strobe length");
	AST_RE_READ: assert property (!nand_re_n |-> !nand_io_oe && !nand_ce_n && nand_we_n)
		else $error("bus driven during read");
	AST_WE_HOLD: assert property ($rose(nand_we_n) |-> $stable(nand_io_out) && $stable(nand_cle) && $stable(nand_ale))
		else $error("bus moved at strobe rise");
endmodule // ncps_host_monitor
`default_nettype wire

/* File: verif/ncps_nand_model.sv */
// ncps_nand_model.sv: behavioural nand device for the host bench
// assumes: strobes last several hclk cycles; hclk times busy and samples the strobe edges
`timescale 1ns/10ps
`default_nettype none
module ncps_nand_model #(
	parameter int          T_XFER = 20,
	parameter int          T_PROG = 400,
	parameter int          T_ERS  = 600,
	parameter int          PAGE   = 2176,
	parameter logic [39:0] ID     = 40'h5A3C814217 // arbitrary value
) (
	// pins
	input  wire logic        hclk,
	input  wire logic        ce_n,
	input  wire logic        cle,
	input  wire logic        ale,
	input  wire logic        we_n,
	input  wire logic        re_n,
	input  wire logic [15:0] io_out,
	output logic      [15:0] io_in,
	output logic             rb_n,
	// bench controls
	input  wire logic        wp_n,
	input  wire logic        fail
);
	logic        we_q = 1'b1, re_q = 1'b1, f0_q = 1'b0, f1_q = 1'b0;
	logic [7:0]  mode_q = 8'h00;
	logic [2:0]  idx_q = 3'h0, acnt_q = 3'h0;
	logic [15:0] last_q = 16'h0000;
	int          cbusy = 0, abusy = 0, units = 0;
	wire [7:0]   st = {wp_n, cbusy == 0, abusy == 0, 3'b000, f1_q, f0_q};
	wire [15:0]  val = {8'h00, mode_q == 8'h90 ? ID[39 - 8 * idx_q -: 8] : st};
	// a released bus shows the inverse of its last value
	assign io_in = (!ce_n && !re_n) ? val : ~last_q;
	assign rb_n = cbusy == 0;
	// strobe edges found against hclk
	always @(posedge hclk) begin
		we_q <= we_n;
		re_q <= re_n;
		if (cbusy > 0) cbusy <= cbusy - 1;
		if (abusy > 0) abusy <= abusy - 1;
		if (!ce_n && !re_n) last_q <= val;
		if (re_n && !re_q && mode_q == 8'h90) idx_q <= idx_q + 3'h1;
		if (we_n && !we_q && !ce_n) begin
			if (cle && (cbusy == 0 || io_out[7:0] == 8'h70)) begin
				mode_q <= io_out[7:0];
				idx_q <= 3'h0;
				acnt_q <= 3'h0;
				if (io_out[7:0] == 8'h80) units <= 0;
				if (io_out[7:0] == 8'h15 || io_out[7:0] == 8'h10) begin
					cbusy <= abusy + T_XFER + (io_out[2] ? 0 : T_PROG);
					abusy <= abusy + T_XFER + T_PROG;
					f1_q <= f0_q;
					f0_q <= fail;
				end
				if (io_out[7:0] == 8'hD0 && mode_q == 8'h60 && acnt_q == 3'h3) begin
					cbusy <= T_ERS;
					abusy <= T_ERS;
					f0_q <= fail;
				end
			end else if (ale) acnt_q <= acnt_q + 3'h1;
			else if (!cle && mode_q == 8'h80 && units < PAGE) units <= units + 1;
		end
	end
endmodule // ncps_nand_model
`default_nettype wire

/* File: verif/test_nand_cache_prog_erase_status.sv */
// test_nand_cache_prog_erase_status.sv: bench for the nand host
// assumes: ncps_host, the nand model and the monitor; 200 MHz hclk
`timescale 1ns/10ps
`default_nettype none
`include "ncps_defs.vh"
module test_nand_cache_prog_erase_status;
	localparam logic [39:0] ID = 40'h5A3C814217; // arbitrary value
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic        wp_n = 1'b1, fail = 1'b0, rd_ph = 1'b0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'b00;
	logic [31:0] hwdata = 32'h0, rd, exp_q[$];
	logic [15:0] rnd = 16'h0052;
	logic        f[3];
	int          err_count = 0, check_count = 0;
	wire [31:0]  hrdata;
	wire         hreadyout, hresp, ce_n, cle, ale, we_n, re_n, oe, rb_n;
	wire [15:0]  io_out, io_in;
	always #2.5 hclk = ~hclk;
	ncps_host DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .nand_ce_n(ce_n), .nand_cle(cle),
		.nand_ale(ale), .nand_we_n(we_n), .nand_re_n(re_n), .nand_io_out(io_out),
		.nand_io_oe(oe), .nand_io_in(io_in), .nand_rb_n(rb_n));
	ncps_nand_model #(.ID(ID)) dev (.hclk, .ce_n, .cle, .ale, .we_n, .re_n, .io_out, .io_in,
		.rb_n, .wp_n, .fail);
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic summarize;
		if (err_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// one transfer; a checked read leaves its expected value in the queue
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c,
		input logic [31:0] e);
		int n;
		logic ok;
		hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= a;
		n = 0;
		do begin @(negedge hclk); ok = hreadyout; @(posedge hclk); n++; end while (!ok && n < 2000);
		if (!ok) begin err_count++; summarize(); end
		htrans <= 2'b00; hsel <= 1'b0; hwdata <= d;
		if (c) begin exp_q.push_back(e); rd_ph <= 1'b1; end
		n = 0;
		do begin @(negedge hclk); ok = hreadyout; rd = hrdata; @(posedge hclk); n++; end
		while (!ok && n < 2000);
		rd_ph <= 1'b0;
		if (!ok) begin err_count++; summarize(); end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d, 1'b0, 32'h0);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0, 1'b1, e);
	endtask
	// polls busy; a bounded count stands in for a hang
	task automatic wait_idle;
		int n;
		n = 0;
		do begin ahb(1'b0, `NCPS_REG_CTRL, 32'h0, 1'b0, 32'h0); n++; end
		while (rd[8] !== 1'b0 && n < 20000);
		if (rd[8] !== 1'b0) begin err_count++; summarize(); end
	endtask
	// read results matched against the oldest note as the data phase ends
	always @(posedge hclk) if (rd_ph && hreadyout) begin
		check(hrdata, exp_q.pop_front());
		check({31'h0, hresp}, 32'h0);
	end
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		wr(`NCPS_REG_CTRL, 32'h104);
		wait_idle;
		rdc(`NCPS_REG_ID_LO, {ID[15:8], ID[23:16], ID[31:24], ID[39:32]});
		rdc(`NCPS_REG_ID_HI, {24'h0, ID[7:0]});
		rdc(8'h1C, 32'h0);
		// erase with a random verdict
		rnd = lfsr(rnd);
		f[0] = rnd[0];
		fail <= rnd[0];
		wr(`NCPS_REG_ADDR_LO, {rnd, ~rnd});
		wr(`NCPS_REG_ADDR_HI, {24'h0, rnd[7:0]});
		wr(`NCPS_REG_CTRL, 32'h102);
		wait_idle;
		rdc(`NCPS_REG_STATUS, {24'h0, 7'h70, f[0]});
		rdc(`NCPS_REG_CTRL, {22'h0, f[0], 9'h003});
		// two full x16 pages in one block: 15h first, 10h last
		for (int p = 0; p < 2; p++) begin
			rnd = lfsr(rnd);
			f[p + 1] = rnd[0];
			fail <= rnd[0];
			wr(`NCPS_REG_ADDR_LO, {8'h2A, 2'b00, 6'(p), 16'h0});
			wr(`NCPS_REG_ADDR_HI, 32'h0);
			wr(`NCPS_REG_CTRL, {23'h0, 1'b1, 2'b00, 1'b1, p[0], 1'b0, 3'h1});
			for (int i = 0; i < 2176; i++) begin
				rnd = lfsr(rnd);
				wr(`NCPS_REG_DATA, {16'h0, rnd});
			end
			wait_idle;
			check(32'(dev.units), 32'd2176);
			rdc(`NCPS_REG_STATUS, {24'h0, 2'b11, p[0], 3'b000, f[p], f[p + 1]});
			rdc(`NCPS_REG_CTRL, {22'h0, p ? f[2] : f[0], 3'h0, 1'b1, p[0], 1'b0, 3'h3});
		end
		// status alone with the device protected
		wp_n <= 1'b0;
		wr(`NCPS_REG_CTRL, 32'h103);
		wait_idle;
		rdc(`NCPS_REG_STATUS, {24'h0, 6'b011000, f[1], f[2]});
		repeat (2) @(posedge hclk);
		summarize();
	end
endmodule // test_nand_cache_prog_erase_status
bind ncps_host ncps_host_monitor u_mon (.hclk, .hresetn, .nand_ce_n, .nand_cle, .nand_ale,
	.nand_we_n, .nand_re_n, .nand_io_out, .nand_io_oe, .nand_rb_n);
`default_nettype wire
